// ### rtch_pkg.sv
// Package with register map, field positions and timing counts for the clock unit
package rtch_pkg;
    localparam int          ADDR_W           = 16;
    localparam int          DATA_W           = 8;
    // Register byte addresses
    localparam logic [15:0] ADDR_FLAGS       = 16'hf067;
    localparam logic [15:0] ADDR_SECOND      = 16'hf068;
    localparam logic [15:0] ADDR_MINUTE      = 16'hf069;
    localparam logic [15:0] ADDR_HOUR        = 16'hf06a;
    localparam logic [15:0] ADDR_WEEKDAY     = 16'hf06b;
    localparam logic [15:0] ADDR_CTRL_ONE    = 16'hf06c;
    localparam logic [15:0] ADDR_CTRL_TWO    = 16'hf06d;
    localparam logic [15:0] ADDR_FREE_CNT    = 16'hf06e;
    localparam logic [15:0] ADDR_SRC_SEL     = 16'hf06f;
    localparam logic [15:0] ADDR_IRQ_EN_ONE  = 16'hfff3;
    // Field positions
    localparam int          CTRL_ONE_RUN     = 7;
    localparam int          CTRL_ONE_SRST    = 4;
    localparam int          HALF_SEC_BIT     = 1;
    localparam int          OVF_BIT          = 0;
    localparam int          IRQ_GLOBAL_BIT   = 7;
    localparam int          SRC_CAL_BIT      = 3;
    // Reset values
    localparam logic [3:0]  SRC_SEL_RST      = 4'h0;
    localparam logic [7:0]  BYTE_ZERO        = 8'h00;
    // Calendar limits
    localparam logic [7:0]  SEC_LAST         = 8'h3b;
    localparam logic [7:0]  MIN_LAST         = 8'h3b;
    localparam logic [7:0]  HOUR_LAST        = 8'h17;
    localparam logic [7:0]  WEEKDAY_LAST     = 8'h06;
    // Timing: subclock in Hz, half second in ms, subclock edges per half second
    localparam int          SUBCLK_HZ        = 32768;
    localparam int          HALF_SEC_MS      = 500;
    localparam int          HALF_SEC_EDGES   = SUBCLK_HZ * HALF_SEC_MS / 1000;
    localparam logic [13:0] HALF_SEC_LAST    = 14'(HALF_SEC_EDGES - 1);
    // Free-running prescaler masks (divider minus one) for codes 0..7
    localparam int          PRE_W            = 13;
    localparam logic [12:0] DIV_MASK [8]     = '{13'h0007, 13'h001f, 13'h007f, 13'h00ff,
                                                 13'h01ff, 13'h07ff, 13'h0fff, 13'h1fff};
endpackage

// ### rtch_core.sv
// Clock unit control: run/stop, soft reset, source select, half-second interrupt
`timescale 1ns/1ps

// Behaviour
// - Run bit one counts, zero halts.
// - Soft reset clears all but selector, global enable, itself.
// - Half-second interrupt only while enable set.
// - Selector 0xxx: free counter, divided clock.
// - Selector 1xxx: calendar from 32.768 kHz.
// - Global enable gates requests to processor.
// - Flag set by event, cleared writing zero.
// - Time counts survive external reset input.
module rtch_core
    import rtch_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              subclk,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    output logic                   irq
);

    // Bus decode
    logic wr_flags;
    logic wr_sec;
    logic wr_min;
    logic wr_hour;
    logic wr_wday;
    logic wr_ctl1;
    logic wr_ctl2;
    logic wr_frc;
    logic wr_src;
    logic wr_ie1;

    always_comb begin
        wr_flags = wr && (addr == ADDR_FLAGS);
        wr_sec   = wr && (addr == ADDR_SECOND);
        wr_min   = wr && (addr == ADDR_MINUTE);
        wr_hour  = wr && (addr == ADDR_HOUR);
        wr_wday  = wr && (addr == ADDR_WEEKDAY);
        wr_ctl1  = wr && (addr == ADDR_CTRL_ONE);
        wr_ctl2  = wr && (addr == ADDR_CTRL_TWO);
        wr_frc   = wr && (addr == ADDR_FREE_CNT);
        wr_src   = wr && (addr == ADDR_SRC_SEL);
        wr_ie1   = wr && (addr == ADDR_IRQ_EN_ONE);
    end

    // Control registers
    logic       run_ff;
    logic       srst_ff;
    logic       hs_en_ff;
    logic       ovf_en_ff;
    logic [3:0] src_ff;
    logic       gie_ff;
    logic       nxt_run;
    logic       nxt_srst;
    logic       nxt_hs_en;
    logic       nxt_ovf_en;
    logic [3:0] nxt_src;
    logic       nxt_gie;

    always_comb begin
        nxt_run    = run_ff;
        nxt_srst   = srst_ff;
        nxt_hs_en  = hs_en_ff;
        nxt_ovf_en = ovf_en_ff;
        nxt_src    = src_ff;
        nxt_gie    = gie_ff;
        if (wr_ctl1) begin
            nxt_run  = wdata[CTRL_ONE_RUN];
            nxt_srst = wdata[CTRL_ONE_SRST];
        end
        if (wr_ctl2) begin
            nxt_hs_en  = wdata[HALF_SEC_BIT];
            nxt_ovf_en = wdata[OVF_BIT];
        end
        if (wr_src) begin
            nxt_src = wdata[3:0];
        end
        if (wr_ie1) begin
            nxt_gie = wdata[IRQ_GLOBAL_BIT];
        end
        // Held soft reset keeps the rest cleared until software drops it
        if (srst_ff) begin
            nxt_hs_en  = 1'b0;
            nxt_ovf_en = 1'b0;
            if (!wr_ctl1) begin
                nxt_run = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            run_ff    <= 1'b0;
            srst_ff   <= 1'b0;
            hs_en_ff  <= 1'b0;
            ovf_en_ff <= 1'b0;
            src_ff    <= SRC_SEL_RST;
            gie_ff    <= 1'b0;
        end else begin
            run_ff    <= nxt_run;
            srst_ff   <= nxt_srst;
            hs_en_ff  <= nxt_hs_en;
            ovf_en_ff <= nxt_ovf_en;
            src_ff    <= nxt_src;
            gie_ff    <= nxt_gie;
        end
    end

    // Tick generation
    logic              calendar;
    logic              counting;
    logic              sub_meta_ff;
    logic              sub_sync_ff;
    logic              sub_prev_ff;
    logic              sub_edge;
    logic [PRE_W-1:0]  pre_ff;
    logic [PRE_W-1:0]  nxt_pre;
    logic [13:0]       hs_cnt_ff;
    logic [13:0]       nxt_hs_cnt;
    logic              frc_tick;
    logic              hs_tick;

    always_comb begin
        calendar = src_ff[SRC_CAL_BIT];
        counting = run_ff && !srst_ff;
        sub_edge = sub_sync_ff && !sub_prev_ff;
        nxt_pre  = pre_ff;
        frc_tick = 1'b0;
        if (counting && !calendar) begin
            nxt_pre  = pre_ff + 13'h0001;
            frc_tick = ((pre_ff & DIV_MASK[src_ff[2:0]]) == DIV_MASK[src_ff[2:0]]);
        end
        nxt_hs_cnt = hs_cnt_ff;
        hs_tick    = 1'b0;
        if (counting && calendar && sub_edge) begin
            if (hs_cnt_ff == HALF_SEC_LAST) begin
                nxt_hs_cnt = 14'h0000;
                hs_tick    = 1'b1;
            end else begin
                nxt_hs_cnt = hs_cnt_ff + 14'h0001;
            end
        end
        if (srst_ff) begin
            nxt_pre    = 13'h0000;
            nxt_hs_cnt = 14'h0000;
        end
    end

    // Subclock sampled into the system clock; the edge is taken from the second and third stages
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sub_meta_ff <= 1'b0;
            sub_sync_ff <= 1'b0;
            sub_prev_ff <= 1'b0;
            pre_ff      <= 13'h0000;
            hs_cnt_ff   <= 14'h0000;
        end else begin
            sub_meta_ff <= subclk;
            sub_sync_ff <= sub_meta_ff;
            sub_prev_ff <= sub_sync_ff;
            pre_ff      <= nxt_pre;
            hs_cnt_ff   <= nxt_hs_cnt;
        end
    end

    // Time counts; no reset_n term so power-on contents are undefined
    logic       half_ff;
    logic [7:0] sec_ff;
    logic [7:0] min_ff;
    logic [7:0] hour_ff;
    logic [7:0] wday_ff;
    logic [7:0] frc_ff;
    logic       nxt_half;
    logic [7:0] nxt_sec;
    logic [7:0] nxt_min;
    logic [7:0] nxt_hour;
    logic [7:0] nxt_wday;
    logic [7:0] nxt_frc;
    logic       frc_ovf;

    always_comb begin
        nxt_half = half_ff;
        nxt_sec  = sec_ff;
        nxt_min  = min_ff;
        nxt_hour = hour_ff;
        nxt_wday = wday_ff;
        nxt_frc  = frc_ff;
        frc_ovf  = 1'b0;
        if (hs_tick) begin
            nxt_half = !half_ff;
            if (half_ff) begin
                nxt_sec = sec_ff + 8'h01;
                if (sec_ff == SEC_LAST) begin
                    nxt_sec = BYTE_ZERO;
                    nxt_min = min_ff + 8'h01;
                    if (min_ff == MIN_LAST) begin
                        nxt_min  = BYTE_ZERO;
                        nxt_hour = hour_ff + 8'h01;
                        if (hour_ff == HOUR_LAST) begin
                            nxt_hour = BYTE_ZERO;
                            nxt_wday = (wday_ff == WEEKDAY_LAST) ? BYTE_ZERO : wday_ff + 8'h01;
                        end
                    end
                end
            end
        end
        if (frc_tick) begin
            nxt_frc = frc_ff + 8'h01;
            frc_ovf = (frc_ff == 8'hff);
        end
        if (wr_sec) begin
            nxt_sec = wdata;
        end
        if (wr_min) begin
            nxt_min = wdata;
        end
        if (wr_hour) begin
            nxt_hour = wdata;
        end
        if (wr_wday) begin
            nxt_wday = wdata;
        end
        if (wr_frc) begin
            nxt_frc = wdata;
        end
        if (srst_ff) begin
            nxt_half = 1'b0;
            nxt_sec  = BYTE_ZERO;
            nxt_min  = BYTE_ZERO;
            nxt_hour = BYTE_ZERO;
            nxt_wday = BYTE_ZERO;
            nxt_frc  = BYTE_ZERO;
        end
    end

    always_ff @(posedge mclk) begin
        half_ff <= nxt_half;
        sec_ff  <= nxt_sec;
        min_ff  <= nxt_min;
        hour_ff <= nxt_hour;
        wday_ff <= nxt_wday;
        frc_ff  <= nxt_frc;
    end

    // Interrupt flags: event wins over a clearing write in the same cycle
    logic hs_flag_ff;
    logic ovf_flag_ff;
    logic nxt_hs_flag;
    logic nxt_ovf_flag;

    always_comb begin
        nxt_hs_flag  = hs_flag_ff;
        nxt_ovf_flag = ovf_flag_ff;
        if (wr_flags && hs_flag_ff && !wdata[HALF_SEC_BIT]) begin
            nxt_hs_flag = 1'b0;
        end
        if (wr_flags && ovf_flag_ff && !wdata[OVF_BIT]) begin
            nxt_ovf_flag = 1'b0;
        end
        if (hs_tick) begin
            nxt_hs_flag = 1'b1;
        end
        if (frc_ovf) begin
            nxt_ovf_flag = 1'b1;
        end
        if (srst_ff) begin
            nxt_hs_flag  = 1'b0;
            nxt_ovf_flag = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hs_flag_ff  <= 1'b0;
            ovf_flag_ff <= 1'b0;
        end else begin
            hs_flag_ff  <= nxt_hs_flag;
            ovf_flag_ff <= nxt_ovf_flag;
        end
    end

    // Level request; flags stay visible to polling even while masked
    always_comb begin
        irq = gie_ff && ((hs_flag_ff && hs_en_ff) || (ovf_flag_ff && ovf_en_ff));
    end

    // Read port: data valid in the cycle after the strobe only
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;

    always_comb begin
        nxt_rdata = BYTE_ZERO;
        if (rd) begin
            case (addr)
                ADDR_FLAGS: begin
                    nxt_rdata[HALF_SEC_BIT] = hs_flag_ff;
                    nxt_rdata[OVF_BIT]      = ovf_flag_ff;
                end
                ADDR_SECOND: begin
                    nxt_rdata = sec_ff;
                end
                ADDR_MINUTE: begin
                    nxt_rdata = min_ff;
                end
                ADDR_HOUR: begin
                    nxt_rdata = hour_ff;
                end
                ADDR_WEEKDAY: begin
                    nxt_rdata = wday_ff;
                end
                ADDR_CTRL_ONE: begin
                    nxt_rdata[CTRL_ONE_RUN]  = run_ff;
                    nxt_rdata[CTRL_ONE_SRST] = srst_ff;
                end
                ADDR_CTRL_TWO: begin
                    nxt_rdata[HALF_SEC_BIT] = hs_en_ff;
                    nxt_rdata[OVF_BIT]      = ovf_en_ff;
                end
                ADDR_FREE_CNT: begin
                    nxt_rdata = frc_ff;
                end
                ADDR_SRC_SEL: begin
                    nxt_rdata[3:0] = src_ff;
                end
                ADDR_IRQ_EN_ONE: begin
                    nxt_rdata[IRQ_GLOBAL_BIT] = gie_ff;
                end
                default: begin
                    nxt_rdata = BYTE_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdata_ff <= BYTE_ZERO;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    always_comb begin
        rdata = rdata_ff;
    end

endmodule

// ### rtch_core_chk.sv
// Checker for bus answers and interrupt gating of the clock unit
`timescale 1ns/1ps
module rtch_core_chk
    import rtch_pkg::*;
(
    input wire logic              mclk,
    input wire logic              reset_n,
    input wire logic              subclk,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              irq
);
    // Shadows of the two fields that soft reset must leave alone
    logic [3:0] src_ff;
    logic [3:0] nxt_src;
    logic       gie_ff;
    logic       nxt_gie;
    always_comb begin
        nxt_src = src_ff;
        nxt_gie = gie_ff;
        if (wr && addr == ADDR_SRC_SEL) nxt_src = wdata[3:0];
        if (wr && addr == ADDR_IRQ_EN_ONE) nxt_gie = wdata[7];
    end
    always_ff @(posedge mclk) begin
        src_ff <= reset_n ? nxt_src : SRC_SEL_RST;
        gie_ff <= reset_n & nxt_gie;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_ctrl1_layout: assert property (rd && addr == ADDR_CTRL_ONE |=> (rdata & 8'h6f) == 8'h00)
        else $error("control one reads unused bits");
    // Flags and enables clear one edge after the soft reset bit lands
    a_srst_quiet: assert property (wr && addr == ADDR_CTRL_ONE && wdata[4] |-> ##2 !irq [*3])
        else $error("interrupt high during soft reset");
    a_src_kept: assert property (rd && addr == ADDR_SRC_SEL |=> rdata == {4'h0, src_ff})
        else $error("source select read differs from last write");
    a_en_gate: assert property (wr && addr == ADDR_CTRL_TWO && wdata[1:0] == 2'b00 |=> !irq)
        else $error("interrupt high with enables off");
    a_ctrl2_layout: assert property (rd && addr == ADDR_CTRL_TWO |=> rdata[7:2] == 6'h00)
        else $error("control two reads unused bits");
    a_irq_gie: assert property (irq |-> gie_ff)
        else $error("interrupt high with global enable off");
    a_gie_read: assert property (rd && addr == ADDR_IRQ_EN_ONE |=> rdata[7] == gie_ff)
        else $error("global enable read differs from last write");
    a_flag_w1: assert property (wr && addr == ADDR_FLAGS && wdata == 8'hff && irq |=> irq)
        else $error("writing ones cleared a flag");
endmodule

bind rtch_core rtch_core_chk u_rtch_core_chk (.mclk(mclk), .reset_n(reset_n), .subclk(subclk),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

// ### test_rtch_core.sv
// Self-checking bench for the clock unit control block
`timescale 1ns/1ps
module test_rtch_core;
    import rtch_pkg::*;
    logic              mclk      = 1'b0;
    logic              reset_n   = 1'b0;
    logic              subclk    = 1'b0;
    logic [ADDR_W-1:0] addr      = '0;
    logic [DATA_W-1:0] wdata     = '0;
    logic              wr        = 1'b0;
    logic              rd        = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    int                n_fail    = 0;
    int                cmp_count = 0;
    int                cyc       = 0;
    int                divs [8]  = '{8, 32, 128, 256, 512, 2048, 4096, 8192};
    always #50 mclk = ~mclk;
    rtch_core u_rtch_core (.mclk(mclk), .reset_n(reset_n), .subclk(subclk), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Ceiling sits above the roughly 86k cycles the sequence needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic exp);
        #1;
        cmp_count++;
        if (irq !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, irq, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // An idle edge after each strobe keeps the strobe from being driven twice in one step
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        cmp8(rdata, exp);
        @(posedge mclk);
    endtask
    task automatic edges(input int n);
        repeat (n) begin
            subclk <= 1'b1;
            @(posedge mclk);
            subclk <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task automatic t_reset();
        rd_chk(ADDR_CTRL_ONE, 8'h00);
        rd_chk(ADDR_CTRL_TWO, 8'h00);
        rd_chk(ADDR_FLAGS, 8'h00);
        rd_chk(ADDR_SRC_SEL, 8'h00);
        rd_chk(ADDR_IRQ_EN_ONE, 8'h00);
        wr_reg(16'h1234, 8'hff);
        rd_chk(16'h1234, 8'h00);
        cmp_bit(1'b0);
    endtask
    task automatic t_keep();
        wr_reg(ADDR_SECOND, 8'h05);
        reset_n <= 1'b0;
        idle(2);
        reset_n <= 1'b1;
        idle(1);
        rd_chk(ADDR_SECOND, 8'h05);
    endtask
    // Sample halfway between ticks so bus write and read latency cannot move the count
    task automatic t_free();
        int div;
        for (int c = 0; c < 8; c++) begin
            div = divs[c];
            wr_reg(ADDR_SRC_SEL, 8'(c));
            wr_reg(ADDR_CTRL_ONE, 8'h10);
            wr_reg(ADDR_CTRL_ONE, 8'h80);
            idle(div * 2 + div / 2 - 2);
            rd_chk(ADDR_FREE_CNT, 8'h02);
            wr_reg(ADDR_CTRL_ONE, 8'h00);
            idle(div);
            rd_chk(ADDR_FREE_CNT, 8'h02);
        end
    endtask
    task automatic t_half();
        wr_reg(ADDR_CTRL_ONE, 8'h10);
        wr_reg(ADDR_CTRL_ONE, 8'h00);
        wr_reg(ADDR_SRC_SEL, 8'h0f);
        wr_reg(ADDR_CTRL_TWO, 8'h02);
        wr_reg(ADDR_IRQ_EN_ONE, 8'h80);
        wr_reg(ADDR_CTRL_ONE, 8'h80);
        edges(16383);
        idle(4);
        rd_chk(ADDR_FLAGS, 8'h00);
        cmp_bit(1'b0);
        edges(1);
        idle(4);
        rd_chk(ADDR_FLAGS, 8'h02);
        cmp_bit(1'b1);
        wr_reg(ADDR_CTRL_TWO, 8'h00);
        cmp_bit(1'b0);
        wr_reg(ADDR_CTRL_TWO, 8'h02);
        wr_reg(ADDR_IRQ_EN_ONE, 8'h00);
        cmp_bit(1'b0);
        wr_reg(ADDR_IRQ_EN_ONE, 8'h80);
        wr_reg(ADDR_FLAGS, 8'hff);
        cmp_bit(1'b1);
        wr_reg(ADDR_FLAGS, 8'h00);
        rd_chk(ADDR_FLAGS, 8'h00);
        cmp_bit(1'b0);
    endtask
    // Raise the request through a counter overflow so soft reset has something to clear
    task automatic t_srst();
        wr_reg(ADDR_SRC_SEL, 8'h00);
        wr_reg(ADDR_FREE_CNT, 8'hff);
        wr_reg(ADDR_CTRL_TWO, 8'h01);
        idle(8);
        wr_reg(ADDR_SRC_SEL, 8'h0f);
        cmp_bit(1'b1);
        wr_reg(ADDR_CTRL_ONE, 8'h90);
        rd_chk(ADDR_CTRL_ONE, 8'h10);
        rd_chk(ADDR_CTRL_TWO, 8'h00);
        rd_chk(ADDR_SRC_SEL, 8'h0f);
        rd_chk(ADDR_IRQ_EN_ONE, 8'h80);
        rd_chk(ADDR_FLAGS, 8'h00);
        cmp_bit(1'b0);
        wr_reg(ADDR_CTRL_ONE, 8'h80);
        rd_chk(ADDR_CTRL_ONE, 8'h80);
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_keep();
        t_free();
        t_half();
        t_srst();
        wrap_up();
    end
endmodule
